// >>> rtl/hpdt_pkg.sv
// Purpose: constants and types for the host pad and decode test block
// Assumes: AHB-Lite register access, 32-bit words
// Notes: byte values are full chip test register codes
package hpdt_pkg;
  localparam logic [7:0] OFS_TEST = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_COUNTER = 8'h08;
  localparam logic [7:0] CODE_INPAD = 8'h29;
  localparam logic [7:0] CODE_OSC = 8'h2B;
  localparam logic [7:0] CODE_ILLMON = 8'h2C;
  localparam logic [7:0] CODE_OHIGH = 8'h49;
  localparam logic [7:0] CODE_OLOW = 8'h69;
  localparam int BIT_HOST_EN = 3;
  localparam int RING_LEVELS = 101;
  localparam int PAD_COUNT = 32;
  localparam int STR_COUNT = 8;
  localparam int WIDE_STR = 43;
  localparam int NARROW_STR = 8;
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
  localparam logic [31:0] COUNTER_RESET = 32'h0000_0000;
  localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

  typedef enum logic [3:0] {
    HPDT_NORMAL,
    HPDT_OTHER,
    HPDT_INPAD,
    HPDT_OSC,
    HPDT_ILLMON,
    HPDT_OHI_ARM,
    HPDT_OHI,
    HPDT_OLO_ARM,
    HPDT_OLO
  } hpdt_mode_t;

  typedef struct packed {
    hpdt_mode_t mode;
    logic host_en;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [31:0] rdata;
    logic [31:0] counter;
    logic [RING_LEVELS-1:0] ring;
    logic tap;
    logic chrdy;
    logic [6:0] upper;
    logic bit16;
    logic [PAD_COUNT-1:0] drv_en;
    logic [PAD_COUNT-1:0] drv_val;
    logic err_rst;
    logic pause;
    logic readyout;
  } hpdt_state_t;
endpackage : hpdt_pkg

// >>> rtl/hpdt_top.sv
// Purpose: host interface cell pad, oscillator and illegal address tests
// Assumes: one 10 MHz clock, synchronous pins, rst is the chip reset
// Notes: the ring is a flop delay line so it stays synthesizable
//
// Contract
// - input pad test puts eight strings on upper outputs
// - string output high only when all inputs high
// - bus reset with ready low keeps input pad selection held
// - bus reset ignored in string while ready high
// - scsi string input joins the string structure
// - write or bus reset leaves pad/osc/monitor
// - output high after next ready rising edge
// - output low after next ready rising edge
// - drive tests end only on bus reset
// - process check chains strings into inverting ring
// - ring spans 101 cell levels
// - ring tap clocks 32-bit host address counter
// - ready runs ring, synchronized pause freezes count
// - bus reset, bus clock, chip clock forced high
// - fixed string order, tap from byte-enable string
// - string outputs shown during process check
// - monitor puts illegal flags on 18..16, zeros above
// - monitor holds error register in reset
// - monitor stops illegal access forcing pause
// - write with ready high clears host test enable
// - decode codes 29, 2B, 2C, 49, 69
//
// Implementation choices: the address map and the AHB-Lite register port.
`timescale 1ns/1ps
module hpdt_top (
  input wire logic clock,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic bus_reset_input,
  input wire logic channel_ready_input,
  input wire logic chip_clock_input,
  input wire logic bus_clock_input,
  input wire logic scsi_and_string_input,
  input wire logic [hpdt_pkg::NARROW_STR-4:0] str23_pads,
  input wire logic [hpdt_pkg::WIDE_STR-1:0] str22_pads,
  input wire logic [hpdt_pkg::NARROW_STR-3:0] str21_pads,
  input wire logic [hpdt_pkg::NARROW_STR-1:0] str20_pads,
  input wire logic [hpdt_pkg::NARROW_STR-1:0] str19_pads,
  input wire logic [hpdt_pkg::NARROW_STR-1:0] str18_pads,
  input wire logic [hpdt_pkg::NARROW_STR-1:0] str17_pads,
  input wire logic [hpdt_pkg::NARROW_STR-1:0] str16_pads,
  input wire logic [7:0] master_address_in,
  input wire logic haddr_count_step,
  input wire logic ill_host_addr,
  input wire logic ill_seq_addr,
  input wire logic ill_opcode,
  input wire logic illegal_pause_req,
  output logic [6:0] upper_address_outputs,
  output logic address_bit16_output,
  output logic [hpdt_pkg::PAD_COUNT-1:0] pad_out_enable,
  output logic [hpdt_pkg::PAD_COUNT-1:0] pad_out_value,
  output logic error_reg_reset,
  output logic seq_pause_force,
  output logic host_test_enable
);
  hpdt_pkg::hpdt_state_t s_q;
  hpdt_pkg::hpdt_state_t s_d;
  logic [hpdt_pkg::STR_COUNT-1:0] str_and;
  logic [hpdt_pkg::RING_LEVELS-1:0] ring_next;
  logic strobe_ok;
  logic bus_reset_input_term;
  logic clk_term;
  logic bclk_term;
  logic ring_run;

  function automatic hpdt_pkg::hpdt_mode_t decode_code(
    input logic [7:0] code
  );
    hpdt_pkg::hpdt_mode_t m;
    m = hpdt_pkg::HPDT_OTHER;
    case (code)
      hpdt_pkg::CODE_INPAD: m = hpdt_pkg::HPDT_INPAD;
      hpdt_pkg::CODE_OSC: m = hpdt_pkg::HPDT_OSC;
      hpdt_pkg::CODE_ILLMON: m = hpdt_pkg::HPDT_ILLMON;
      hpdt_pkg::CODE_OHIGH: m = hpdt_pkg::HPDT_OHI_ARM;
      hpdt_pkg::CODE_OLOW: m = hpdt_pkg::HPDT_OLO_ARM;
      default: m = hpdt_pkg::HPDT_OTHER;
    endcase
    return m;
  endfunction : decode_code

  function automatic logic [31:0] read_word(
    input logic [7:0] a,
    input hpdt_pkg::hpdt_state_t s
  );
    logic [31:0] w;
    w = 32'h0000_0000;
    case (a)
      hpdt_pkg::OFS_STATUS: w = {26'h00_0000, s.host_en, 1'b0, s.mode};
      hpdt_pkg::OFS_COUNTER: w = s.counter;
      default: w = 32'h0000_0000;
    endcase
    return w;
  endfunction : read_word

  function automatic logic drive_mode(input hpdt_pkg::hpdt_mode_t m);
    return (m == hpdt_pkg::HPDT_OHI_ARM) || (m == hpdt_pkg::HPDT_OHI) ||
           (m == hpdt_pkg::HPDT_OLO_ARM) || (m == hpdt_pkg::HPDT_OLO);
  endfunction : drive_mode

  // in oscillator mode the clock and reset pins would stop the ring
  assign clk_term = (s_q.mode == hpdt_pkg::HPDT_OSC) |
                    chip_clock_input;
  assign bclk_term = (s_q.mode == hpdt_pkg::HPDT_OSC) |
                     bus_clock_input;
  // while ready is high the reset pin is still a reset, not a test input
  assign bus_reset_input_term = (s_q.mode == hpdt_pkg::HPDT_OSC) |
                       channel_ready_input |
                       bus_reset_input;

  // bit order of each string: str_and index i drives address bit 16+i (index 0 on bit16, 1..7 on upper bits 0..6)
  assign str_and[7] = &{clk_term, bus_reset_input_term, str23_pads};
  assign str_and[6] = &{str22_pads, scsi_and_string_input};
  assign str_and[5] = &{channel_ready_input, bclk_term,
                        str21_pads};
  assign str_and[4] = &str20_pads;
  assign str_and[3] = &str19_pads;
  assign str_and[2] = &str18_pads;
  assign str_and[1] = &str17_pads;
  assign str_and[0] = &str16_pads;

  // pause is taken from the registered ready so the count is not torn
  assign ring_run = s_q.chrdy & (s_q.mode == hpdt_pkg::HPDT_OSC);

  // chain order 22, 23, 16, 17, 18, 19, 20, 21; level 0 holds the inversion
  assign ring_next[0] = ring_run & ~s_q.ring[hpdt_pkg::RING_LEVELS-1] &
                        str_and[6] & str_and[7] & str_and[0] &
                        str_and[1] & str_and[2] & str_and[3] &
                        str_and[4] & str_and[5];
  genvar gi;
  generate
    for (gi = 1; gi < hpdt_pkg::RING_LEVELS; gi++) begin : g_ring
      assign ring_next[gi] = ring_run & s_q.ring[gi-1];
    end
  endgenerate

  assign strobe_ok = hsel & hready & htrans[1];

  always_comb begin
    hpdt_pkg::hpdt_mode_t m;
    logic [7:0] wb;
    m = s_q.mode;
    wb = hwdata[7:0];
    s_d = s_q;
    s_d.readyout = 1'b1;
    s_d.chrdy = channel_ready_input;
    s_d.ring = ring_next;
    s_d.tap = s_q.ring[hpdt_pkg::RING_LEVELS-1];

    // bus slave: zero wait, reads captured in the address phase
    s_d.wr_pend = strobe_ok & hwrite;
    s_d.wr_addr = haddr[7:0];
    if (strobe_ok && !hwrite) begin
      s_d.rdata = read_word(haddr[7:0], s_q);
    end

    // mode transitions
    if (bus_reset_input) begin
      if (m == hpdt_pkg::HPDT_INPAD && !channel_ready_input) begin
        m = hpdt_pkg::HPDT_INPAD;
      end else begin
        m = hpdt_pkg::HPDT_NORMAL;
      end
      s_d.host_en = (m != hpdt_pkg::HPDT_NORMAL);
    end else if (s_q.wr_pend && s_q.wr_addr == hpdt_pkg::OFS_TEST &&
                 !drive_mode(m)) begin
      if (channel_ready_input || !wb[hpdt_pkg::BIT_HOST_EN]) begin
        m = hpdt_pkg::HPDT_NORMAL;
        s_d.host_en = 1'b0;
      end else begin
        m = decode_code(wb);
        s_d.host_en = 1'b1;
      end
    end else if (s_q.wr_pend && !drive_mode(m) &&
                 (m == hpdt_pkg::HPDT_INPAD || m == hpdt_pkg::HPDT_OSC ||
                  m == hpdt_pkg::HPDT_ILLMON)) begin
      m = hpdt_pkg::HPDT_NORMAL;
      s_d.host_en = 1'b0;
    end else if (channel_ready_input && !s_q.chrdy) begin
      case (m)
        hpdt_pkg::HPDT_OHI_ARM: m = hpdt_pkg::HPDT_OHI;
        hpdt_pkg::HPDT_OLO_ARM: m = hpdt_pkg::HPDT_OLO;
        default: m = m;
      endcase
    end
    s_d.mode = m;

    // host address counter: ring tap replaces the normal step
    if (s_q.mode == hpdt_pkg::HPDT_OSC) begin
      if (s_q.ring[hpdt_pkg::RING_LEVELS-1] && !s_q.tap) begin
        s_d.counter = s_q.counter + 32'h0000_0001;
      end
    end else if (haddr_count_step) begin
      s_d.counter = s_q.counter + 32'h0000_0001;
    end

    // output pins
    s_d.drv_en = '0;
    s_d.drv_val = '0;
    s_d.err_rst = 1'b0;
    s_d.pause = illegal_pause_req;
    case (m)
      hpdt_pkg::HPDT_INPAD, hpdt_pkg::HPDT_OSC: begin
        s_d.upper = str_and[7:1];
        s_d.bit16 = str_and[0];
      end
      hpdt_pkg::HPDT_ILLMON: begin
        s_d.upper = {5'h0, ill_host_addr, ill_seq_addr};
        s_d.bit16 = ill_opcode;
        s_d.err_rst = 1'b1;
        s_d.pause = 1'b0;
      end
      hpdt_pkg::HPDT_OHI: begin
        s_d.drv_en = '1;
        s_d.drv_val = '1;
        s_d.upper = 7'h7F;
        s_d.bit16 = 1'b1;
      end
      hpdt_pkg::HPDT_OLO: begin
        s_d.drv_en = '1;
        s_d.drv_val = '0;
        s_d.upper = 7'h00;
        s_d.bit16 = 1'b0;
      end
      default: begin
        s_d.upper = master_address_in[7:1];
        s_d.bit16 = master_address_in[0];
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      s_q <= '{mode: hpdt_pkg::HPDT_NORMAL, host_en: 1'b0, wr_pend: 1'b0,
               wr_addr: 8'h00, rdata: hpdt_pkg::RDATA_RESET,
               counter: hpdt_pkg::COUNTER_RESET, ring: '0, tap: 1'b0,
               chrdy: 1'b0, upper: 7'h00, bit16: 1'b0, drv_en: '0,
               drv_val: '0, err_rst: 1'b0, pause: 1'b0, readyout: 1'b1};
    end else begin
      s_q <= s_d;
    end
  end

  assign hreadyout = s_q.readyout;
  assign hrdata = s_q.rdata;
  assign hresp = 1'b0 & s_q.readyout;
  assign upper_address_outputs = s_q.upper;
  assign address_bit16_output = s_q.bit16;
  assign pad_out_enable = s_q.drv_en;
  assign pad_out_value = s_q.drv_val;
  assign error_reg_reset = s_q.err_rst;
  assign seq_pause_force = s_q.pause;
  assign host_test_enable = s_q.host_en;
endmodule : hpdt_top

// >>> tb/hpdt_checker.sv
// Purpose: port checks for hpdt_top
// Assumes: one clock, synchronous rst
// Notes: the mode is inferred from outputs only
`timescale 1ns/1ps
module hpdt_checker (
  input wire logic clock,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hreadyout,
  input wire logic channel_ready_input,
  input wire logic bus_reset_input,
  input wire logic [7:0] master_address_in,
  input wire logic ill_host_addr,
  input wire logic ill_seq_addr,
  input wire logic ill_opcode,
  input wire logic [6:0] upper_address_outputs,
  input wire logic address_bit16_output,
  input wire logic [31:0] pad_out_enable,
  input wire logic [31:0] pad_out_value,
  input wire logic error_reg_reset,
  input wire logic seq_pause_force,
  input wire logic host_test_enable
);
  default clocking dc @(posedge clock);
  endclocking
  default disable iff (rst);
  sequence wr_ready_s;
    hsel && htrans == 2'b10 && hwrite && haddr == 32'h0000_0000 &&
      hreadyout && !pad_out_enable[0] ##1 channel_ready_input;
  endsequence
  // three quiet samples absorb any skew between flag and address stage
  sequence normal_s;
    (!host_test_enable && !$past(rst, 3)) [*3];
  endsequence
  normal_addr_a: assert property (normal_s |->
    {upper_address_outputs, address_bit16_output} == $past(master_address_in))
    else $error("normal address not shown");
  monitor_flags_a: assert property (error_reg_reset [*2] |->
    upper_address_outputs == {5'h0, $past(ill_host_addr),
    $past(ill_seq_addr)} && address_bit16_output == $past(ill_opcode))
    else $error("illegal flags not shown");
  monitor_pause_a: assert property (error_reg_reset |->
    !seq_pause_force) else $error("pause forced in monitor");
  drive_enable_a: assert property (pad_out_enable != 32'h0000_0000 |->
    pad_out_enable == 32'hffff_ffff) else $error("partial pad enable");
  drive_value_a: assert property (pad_out_enable[0] [*2] |->
    $stable(pad_out_value) && (pad_out_value == 32'hffff_ffff ||
    pad_out_value == 32'h0000_0000)) else $error("drive level moved");
  drive_start_a: assert property ($rose(pad_out_enable[0]) |->
    $past(channel_ready_input) && !$past(channel_ready_input, 2))
    else $error("drive began without ready");
  drive_end_a: assert property ($fell(pad_out_enable[0]) |->
    $past(bus_reset_input) || $past(bus_reset_input, 2))
    else $error("drive ended without bus reset");
  test_clear_a: assert property (wr_ready_s |->
    ##[1:2] !host_test_enable) else $error("test enable not cleared");
endmodule : hpdt_checker

// >>> tb/hpdt_tester.sv
// Purpose: part tester pacing channel ready and bus reset
// Assumes: requests come from the bench
// Notes: bus reset waits for ready to drop
`timescale 1ns/1ps
module hpdt_tester (
  input wire logic clock,
  input wire logic ready_req,
  input wire logic reset_req,
  output logic channel_ready_input,
  output logic bus_reset_input
);
  initial begin
    channel_ready_input = 1'b0;
    bus_reset_input = 1'b0;
  end
  always @(posedge clock) begin
    channel_ready_input <= ready_req;
    // ready first, so a pad test selection survives the bus reset
    bus_reset_input <= reset_req && !channel_ready_input && !ready_req;
  end
endmodule : hpdt_tester

// >>> tb/test_hpdt_top.sv
// Purpose: self-checking bench for hpdt_top
// Assumes: tester model paces ready and bus reset
// Notes: ring count is compared only as two counts over one run, its rate is not exact
`timescale 1ns/1ps
module test_hpdt_top;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [96:0] pv = '1;
  logic [7:0] mai = 8'h00;
  logic step = 1'b0;
  logic [2:0] ill = 3'b000;
  logic preq = 1'b0;
  logic rdy_req = 1'b0;
  logic rst_req = 1'b0;
  logic hready, hresp, err_rst, pause, hte, bit16, rdy, bres;
  logic [31:0] hrdata, pen, pval;
  logic [6:0] upper;
  logic [35:0] q[$];
  logic [35:0] e;
  logic [31:0] base;
  int err_count = 0;
  int n_tests = 0;
  always #50 clock = ~clock;
  always @(posedge clock) step <= 1'($urandom);
  hpdt_tester i_tester (.clock(clock), .ready_req(rdy_req),
    .reset_req(rst_req), .channel_ready_input(rdy), .bus_reset_input(bres));
  hpdt_top i_hpdt_top (.clock(clock), .rst(rst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010),
    .hwdata(hwdata), .hready(hready), .hreadyout(hready),
    .hrdata(hrdata), .hresp(hresp), .bus_reset_input(bres),
    .channel_ready_input(rdy), .chip_clock_input(pv[94]),
    .bus_clock_input(pv[95]), .scsi_and_string_input(pv[96]),
    .str23_pads(pv[4:0]), .str22_pads(pv[47:5]), .str21_pads(pv[53:48]),
    .str20_pads(pv[61:54]), .str19_pads(pv[69:62]),
    .str18_pads(pv[77:70]), .str17_pads(pv[85:78]),
    .str16_pads(pv[93:86]), .master_address_in(mai),
    .haddr_count_step(step), .ill_host_addr(ill[2]),
    .ill_seq_addr(ill[1]), .ill_opcode(ill[0]),
    .illegal_pause_req(preq), .upper_address_outputs(upper),
    .address_bit16_output(bit16), .pad_out_enable(pen),
    .pad_out_value(pval), .error_reg_reset(err_rst),
    .seq_pause_force(pause), .host_test_enable(hte));
  function automatic logic [31:0] obs(input logic [3:0] w);
    case (w)
      4'h0: obs = 32'({upper, bit16});
      4'h1: obs = pen;
      4'h2: obs = pval;
      4'h3: obs = hrdata;
      4'h4: obs = 32'({err_rst, pause, hte});
      4'h6: obs = 32'({hresp, hready});
      default: obs = 32'({upper[5], upper[3:0], bit16});
    endcase
  endfunction : obs
  // strings 23 and 21 hold ready and bus reset, so they are left out
  function automatic logic [31:0] pexp();
    pexp = 32'({&pv[47:5] & pv[96], &pv[61:54], &pv[69:62], &pv[77:70],
      &pv[85:78], &pv[93:86]});
  endfunction : pexp
  task automatic want(input logic [3:0] w, input logic [31:0] v);
    q.push_back({w, v});
  endtask : want
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask : cyc
  task automatic bus(input logic wr, input logic [7:0] a,
    input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= 32'(a);
    htrans <= hpdt_pkg::HTRANS_NONSEQ;
    hwrite <= wr;
    do @(posedge clock); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clock); while (hready !== 1'b1);
  endtask : bus
  always @(negedge clock) begin
    while (q.size() > 0) begin
      e = q.pop_front();
      n_tests++;
      if (obs(e[35:32]) !== e[31:0]) begin
        err_count++;
        $display("unexpected at %0t: got %h want %h", $time,
          obs(e[35:32]), e[31:0]);
      end
    end
  end
  task automatic end_of_test;
    if (err_count == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_of_test
  initial begin
    repeat (3000) @(posedge clock);
    err_count++;
    end_of_test();
  end
  initial begin
    void'($urandom(32'h0000_169d));
    cyc(10);
    rst <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      mai <= 8'($urandom);
      cyc(3);
      want(4'h0, 32'(mai));
    end
    bus(1'b0, 8'h10, 32'h0000_0000);
    want(4'h3, 32'h0000_0000);
    want(4'h6, 32'h0000_0001);
    bus(1'b1, hpdt_pkg::OFS_TEST, 32'(hpdt_pkg::CODE_INPAD));
    cyc(2);
    for (int i = 0; i < 8; i++) begin
      pv <= ~(97'h1 << (i == 7 ? 96 : $urandom_range(93, 5)));
      cyc(3);
      want(4'h5, pexp());
    end
    pv <= '1;
    rst_req <= 1'b1;
    cyc(5);
    rst_req <= 1'b0;
    bus(1'b0, hpdt_pkg::OFS_STATUS, 32'h0000_0000);
    want(4'h3, 32'h0000_0022);
    bus(1'b1, hpdt_pkg::OFS_COUNTER, 32'h0000_0000);
    mai <= 8'($urandom);
    cyc(3);
    want(4'h0, 32'(mai));
    bus(1'b1, hpdt_pkg::OFS_TEST, 32'(hpdt_pkg::CODE_ILLMON));
    ill <= 3'($urandom);
    cyc(2);
    preq <= 1'b1;
    cyc(3);
    want(4'h0, 32'(ill));
    want(4'h4, 32'h0000_0005);
    preq <= 1'b0;
    rst_req <= 1'b1;
    cyc(5);
    want(4'h4, 32'h0000_0000);
    rst_req <= 1'b0;
    bus(1'b1, hpdt_pkg::OFS_TEST, 32'(hpdt_pkg::CODE_INPAD));
    rdy_req <= 1'b1;
    cyc(3);
    bus(1'b1, hpdt_pkg::OFS_TEST, 32'(hpdt_pkg::CODE_INPAD));
    cyc(3);
    want(4'h4, 32'h0000_0000);
    rdy_req <= 1'b0;
    cyc(3);
    bus(1'b1, hpdt_pkg::OFS_TEST, 32'(hpdt_pkg::CODE_OSC));
    pv <= ~(97'h1 << $urandom_range(93, 5));
    cyc(3);
    want(4'h5, pexp());
    pv <= '1;
    bus(1'b0, hpdt_pkg::OFS_COUNTER, 32'h0000_0000);
    cyc(1);
    base = hrdata;
    rdy_req <= 1'b1;
    // ring rises near L and 3L cycles in; stopping at 4L gives two counts
    cyc(4 * hpdt_pkg::RING_LEVELS - 4);
    rdy_req <= 1'b0;
    cyc(4);
    for (int i = 0; i < 2; i++) begin
      bus(1'b0, hpdt_pkg::OFS_COUNTER, 32'h0000_0000);
      want(4'h3, base + 32'h0000_0002);
      cyc(hpdt_pkg::RING_LEVELS);
    end
    bus(1'b1, hpdt_pkg::OFS_STATUS, 32'h0000_0000);
    cyc(2);
    want(4'h4, 32'h0000_0000);
    for (int k = 0; k < 2; k++) begin
      bus(1'b1, hpdt_pkg::OFS_TEST, k ? 32'(hpdt_pkg::CODE_OLOW) :
        32'(hpdt_pkg::CODE_OHIGH));
      cyc(3);
      want(4'h1, 32'h0000_0000);
      rdy_req <= 1'b1;
      cyc(4);
      want(4'h1, 32'hffff_ffff);
      want(4'h2, k ? 32'h0000_0000 : 32'hffff_ffff);
      bus(1'b1, hpdt_pkg::OFS_COUNTER, 32'h0000_0000);
      cyc(3);
      want(4'h1, 32'hffff_ffff);
      rdy_req <= 1'b0;
      rst_req <= 1'b1;
      cyc(6);
      want(4'h1, 32'h0000_0000);
      rst_req <= 1'b0;
      cyc(2);
    end
    cyc(2);
    end_of_test();
  end
endmodule : test_hpdt_top
bind hpdt_top hpdt_checker i_hpdt_checker (.clock(clock), .rst(rst),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hreadyout(hreadyout), .channel_ready_input(channel_ready_input),
  .bus_reset_input(bus_reset_input), .master_address_in(master_address_in),
  .ill_host_addr(ill_host_addr), .ill_seq_addr(ill_seq_addr),
  .ill_opcode(ill_opcode), .upper_address_outputs(upper_address_outputs),
  .address_bit16_output(address_bit16_output),
  .pad_out_enable(pad_out_enable), .pad_out_value(pad_out_value),
  .error_reg_reset(error_reg_reset), .seq_pause_force(seq_pause_force),
  .host_test_enable(host_test_enable));
